// ===== hw/bsr_cmd_port.sv
// Command sequencing, burst data path, write buffers and array of the SRAM.
`timescale 1ns/1ps
`include "bsr_params.svh"
module bsr_cmd_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic readSel_n,
	input wire logic writeSel_n,
	input wire logic [`BSR_ADDR_W-1:0] addr,
	input wire logic [`BSR_DATA_W-1:0] dataIn,
	input wire logic [`BSR_LANES-1:0] lane_write_masks_n,
	output logic [`BSR_DATA_W-1:0] dataOut,
	output logic dataOutOe,
	output logic read_data_valid,
	output logic kPhase
);
	// Each clk cycle is one half period of the input clock pair; the divider marks true edges.
	logic phase_reg;
	logic rdSelMeta_reg, rdSel_reg, wrSelMeta_reg, wrSel_reg;
	logic [`BSR_ADDR_W-1:0] addrMeta_reg, addr_reg;
	logic [`BSR_DATA_W-1:0] dataMeta_reg, data_reg;
	logic [`BSR_LANES-1:0] maskMeta_reg, mask_reg;
	bsr_pkg::bsr_rd_state_type rdState_reg;
	bsr_pkg::bsr_wr_state_type wrState_reg;
	logic prevIdle_reg;
	logic [`BSR_SHIFT_W-1:0] rdShift_reg, wrShift_reg;
	logic [`BSR_ADDR_W-1:0] rdAddrA_reg, rdAddrB_reg;
	logic wrSlot_reg;
	logic [`BSR_ADDR_W-1:0] wbAddr_reg [`BSR_SLOTS];
	logic [`BSR_DATA_W-1:0] wbData_reg [`BSR_SLOTS][`BSR_BEATS];
	logic [`BSR_LANES-1:0] wbLane_reg [`BSR_SLOTS][`BSR_BEATS];
	logic wbValid_reg [`BSR_SLOTS];
	// Full depth of the array: every burst base times its four beats.
	logic [`BSR_DATA_W-1:0] memArray [2**`BSR_WORD_W];
	logic trueEdge, readStart, writeStart, nextSlot, beatSlot;
	logic [`BSR_BEATS-1:0] rdBeats, wrBeats;

	// Returns the position of the set bit in a one-hot beat window.
	function automatic logic [1:0] beatIdx(input logic [`BSR_BEATS-1:0] v);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 0; i < `BSR_BEATS; i++) begin
			if (v[i]) begin
				idx = i[1:0];
			end
		end
		return idx;
	endfunction

	// Copies only the lanes whose enables are set and leaves the others as they were.
	function automatic logic [`BSR_DATA_W-1:0] laneMerge(input logic [`BSR_DATA_W-1:0] oldWord,
			input logic [`BSR_DATA_W-1:0] newWord, input logic [`BSR_LANES-1:0] lanes);
		logic [`BSR_DATA_W-1:0] w;
		w = oldWord;
		for (int l = 0; l < `BSR_LANES; l++) begin
			if (lanes[l]) begin
				w[l*`BSR_LANE_W +: `BSR_LANE_W] = newWord[l*`BSR_LANE_W +: `BSR_LANE_W];
			end
		end
		return w;
	endfunction

	// Older slot first, then newer, so the latest write to a lane wins.
	function automatic logic [`BSR_DATA_W-1:0] readWord(input logic [`BSR_ADDR_W-1:0] base, input logic [1:0] beat);
		logic [`BSR_DATA_W-1:0] w;
		logic s;
		w = memArray[{base, beat}];
		for (int k = 0; k < `BSR_SLOTS; k++) begin
			s = (k == 0) ? ~wrSlot_reg : wrSlot_reg;
			if (wbValid_reg[s] && wbAddr_reg[s] == base) begin
				w = laneMerge(w, wbData_reg[s][beat], wbLane_reg[s][beat]);
			end
		end
		return w;
	endfunction

	// Commands count only on true edges; whatever the selects show on complement edges is dropped.
	assign trueEdge = (phase_reg == `BSR_TRUE_PHASE);
	assign readStart = trueEdge && !rdSel_reg && rdState_reg == bsr_pkg::RD_IDLE;
	// A write that collides with a read right after an idle cycle is dropped.
	assign writeStart = trueEdge && !wrSel_reg && wrState_reg == bsr_pkg::WR_IDLE
		&& !(prevIdle_reg && !rdSel_reg);
	// A new write claims the slot that does not hold the write just before it.
	assign nextSlot = ~wrSlot_reg;
	// A write taken two true edges after another still owes its last beat to the older slot.
	assign beatSlot = (wrShift_reg[`BSR_WR_BEAT_HI] && wrShift_reg[`BSR_WR_NEW_TAP]) ? ~wrSlot_reg : wrSlot_reg;
	assign rdBeats = rdShift_reg[`BSR_RD_BEAT_HI:`BSR_RD_BEAT_LO];
	assign wrBeats = wrShift_reg[`BSR_WR_BEAT_HI:`BSR_WR_BEAT_LO];
	// The phase leaves the block so that the controller can line its pins up with true edges.
	assign kPhase = phase_reg;

	// Reset leaves the divider so that the first edge after release is a true edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= `BSR_TRUE_PHASE;
		end else begin
			phase_reg <= ~phase_reg;
		end
	end

	// Every pin goes through the same two stages, so beat timing between pins is kept.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdSelMeta_reg <= `BSR_SEL_INACTIVE;
			rdSel_reg <= `BSR_SEL_INACTIVE;
			wrSelMeta_reg <= `BSR_SEL_INACTIVE;
			wrSel_reg <= `BSR_SEL_INACTIVE;
			addrMeta_reg <= '0;
			addr_reg <= '0;
			dataMeta_reg <= '0;
			data_reg <= '0;
			maskMeta_reg <= `BSR_MASK_INACTIVE;
			mask_reg <= `BSR_MASK_INACTIVE;
		end else begin
			rdSelMeta_reg <= readSel_n;
			rdSel_reg <= rdSelMeta_reg;
			wrSelMeta_reg <= writeSel_n;
			wrSel_reg <= wrSelMeta_reg;
			addrMeta_reg <= addr;
			addr_reg <= addrMeta_reg;
			dataMeta_reg <= dataIn;
			data_reg <= dataMeta_reg;
			maskMeta_reg <= lane_write_masks_n;
			mask_reg <= maskMeta_reg;
		end
	end

	// Two machines whose only shared state is the idle flag, so a read and a write may start on one edge unless a read follows an idle cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdState_reg <= bsr_pkg::RD_IDLE;
			wrState_reg <= bsr_pkg::WR_IDLE;
			prevIdle_reg <= 1'b0;
		end else if (trueEdge) begin
			rdState_reg <= readStart ? bsr_pkg::RD_SECOND : bsr_pkg::RD_IDLE;
			wrState_reg <= writeStart ? bsr_pkg::WR_SECOND : bsr_pkg::WR_IDLE;
			prevIdle_reg <= rdSel_reg && wrSel_reg;
		end
	end

	// Each accepted command walks down its own line, one half cycle per stage, so taps give beat timing.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdShift_reg <= '0;
			wrShift_reg <= '0;
		end else begin
			rdShift_reg <= {rdShift_reg[`BSR_SHIFT_W-2:0], readStart};
			wrShift_reg <= {wrShift_reg[`BSR_SHIFT_W-2:0], writeStart};
		end
	end

	// The second address stage frees the first for a read four half cycles later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdAddrA_reg <= '0;
			rdAddrB_reg <= '0;
		end else begin
			if (readStart) begin
				rdAddrA_reg <= addr_reg;
			end
			if (rdShift_reg[`BSR_RD_ADDR_TAP]) begin
				rdAddrB_reg <= rdAddrA_reg;
			end
		end
	end

	// Beats leave five to eight half cycles after the sampling edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataOut <= '0;
			dataOutOe <= 1'b0;
			read_data_valid <= 1'b0;
		end else begin
			if (|rdBeats) begin
				dataOut <= readWord(rdAddrB_reg, beatIdx(rdBeats));
				dataOutOe <= 1'b1;
			end else begin
				dataOut <= '0;
				dataOutOe <= 1'b0;
			end
			read_data_valid <= |rdShift_reg[`BSR_RD_VALID_HI:`BSR_RD_VALID_LO];
		end
	end

	// Slots alternate; a new write reuses the slot of the write before last.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrSlot_reg <= 1'b0;
			for (int s = 0; s < `BSR_SLOTS; s++) begin
				wbAddr_reg[s] <= '0;
				wbValid_reg[s] <= 1'b0;
				for (int b = 0; b < `BSR_BEATS; b++) begin
					wbData_reg[s][b] <= '0;
					wbLane_reg[s][b] <= '0;
				end
			end
		end else begin
			if (writeStart) begin
				wrSlot_reg <= nextSlot;
				wbAddr_reg[nextSlot] <= addr_reg;
				wbValid_reg[nextSlot] <= 1'b1;
				for (int b = 0; b < `BSR_BEATS; b++) begin
					wbLane_reg[nextSlot][b] <= '0;
				end
			end
			if (|wrBeats) begin
				wbData_reg[beatSlot][beatIdx(wrBeats)] <= data_reg;
				wbLane_reg[beatSlot][beatIdx(wrBeats)] <= ~mask_reg;
			end
		end
	end

	// The array has no reset; a slot reaches it only when a third write displaces it.
	always_ff @(posedge clk) begin
		if (writeStart && wbValid_reg[nextSlot]) begin
			for (int b = 0; b < `BSR_BEATS; b++) begin
				memArray[{wbAddr_reg[nextSlot], b[1:0]}] <= laneMerge(memArray[{wbAddr_reg[nextSlot], b[1:0]}],
					wbData_reg[nextSlot][b], wbLane_reg[nextSlot][b]);
			end
		end
	end
endmodule

// ===== hw/bsr_params.svh
// Constants for the four-beat separate-I/O SRAM command port.
// Notes on behaviour
// - Burst addresses run base plus zero to three.
// - Read select low at true edge requests read.
// - Write select low at true edge requests write.
// - Read and write machines run concurrently; a read after an idle cycle blocks the write.
// - Both machines advance on true edges only.
// - Read beats at t+2.5, 3.0, 3.5, 4.0.
// - Same-type command on next true edge ignored.
// - Both selects after idle cycle: read wins.
// - Low mask writes its nine-bit lane.
// - Buffered writes commit late, reads forward them.
// - Valid leads first beat, drops before last.
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH
`define BSR_ADDR_W 19
`define BSR_WORD_W 21
`define BSR_DATA_W 18
`define BSR_LANE_W 9
`define BSR_LANES 2
`define BSR_BEATS 4
`define BSR_SLOTS 2
`define BSR_SHIFT_W 8
`define BSR_RD_ADDR_TAP 3
`define BSR_RD_VALID_LO 3
`define BSR_RD_VALID_HI 5
`define BSR_RD_BEAT_LO 4
`define BSR_RD_BEAT_HI 7
`define BSR_WR_BEAT_LO 1
`define BSR_WR_BEAT_HI 4
`define BSR_WR_NEW_TAP 0
`define BSR_SEL_INACTIVE 1'b1
`define BSR_MASK_INACTIVE 2'h3
`define BSR_TRUE_PHASE 1'b0
`endif

// ===== hw/bsr_pkg.sv
// Types shared by the SRAM command port.
package bsr_pkg;
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_SECOND = 1'b1
	} bsr_rd_state_type;
	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_SECOND = 1'b1
	} bsr_wr_state_type;
endpackage

// ===== tb/bsr_cmd_port_sva.sv
// Timing checks on the read side of the SRAM command port.
`timescale 1ns/1ps
module bsr_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic readSel_n,
	input wire logic [17:0] dataOut,
	input wire logic dataOutOe,
	input wire logic read_data_valid,
	input wire logic kPhase
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_beats; $rose(dataOutOe) |-> dataOutOe[*4]; endproperty
	a_beats: assert property (p_beats) else $error("short burst");
	// Valid leads each burst by one half cycle, also when two bursts run back to back.
	property p_lead; dataOutOe == ($past(read_data_valid) || $past(read_data_valid, 2)); endproperty
	a_lead: assert property (p_lead) else $error("valid lead");
	property p_vlen; $rose(read_data_valid) |-> read_data_valid[*3] ##1 !read_data_valid; endproperty
	a_vlen: assert property (p_vlen) else $error("valid length");
	property p_lat; $rose(dataOutOe) |-> !$past(readSel_n, 8) && !$past(kPhase, 8); endproperty
	a_lat: assert property (p_lat) else $error("read latency");
	property p_quiet; !dataOutOe |-> dataOut == 18'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("idle output");
	property p_phase; $rose(dataOutOe) |-> !kPhase; endproperty
	a_phase: assert property (p_phase) else $error("beat phase");
	property p_vcause; $rose(read_data_valid) |-> !$past(readSel_n, 7); endproperty
	a_vcause: assert property (p_vcause) else $error("valid cause");
	property p_pair; $rose(dataOutOe) ##4 dataOutOe |-> !$past(readSel_n, 8); endproperty
	a_pair: assert property (p_pair) else $error("read spacing");
	c_rd: cover property ($rose(dataOutOe));
	c_pair: cover property ($rose(dataOutOe) ##4 dataOutOe);
	c_vld: cover property ($rose(read_data_valid));
endmodule

// ===== tb/bsr_ctl_model.sv
// Behavioural memory controller driving the command and write-data pins.
`timescale 1ns/1ps
module bsr_ctl_model (
	input wire logic clk,
	input wire logic kPhase,
	output logic readSel_n = 1'b1,
	output logic writeSel_n = 1'b1,
	output logic [18:0] addr = 19'h0,
	output logic [17:0] dataIn = 18'h0,
	output logic [1:0] lane_write_masks_n = 2'h3
);
	// A command is held for one clock only, so a phase slip shows as a lost command.
	task automatic cmd(input logic r, input logic w, input logic [18:0] a, input logic ph);
		do begin
			@(posedge clk);
			#1;
		end while (kPhase !== ph);
		readSel_n = !r;
		writeSel_n = !w;
		addr = a;
		@(posedge clk);
		#1;
		readSel_n = 1'b1;
		writeSel_n = 1'b1;
		addr = ~a;
	endtask
	// Bursts are always sent whole, so nothing is pending when traffic stops.
	task automatic data(input logic [143:0] d, input logic [15:0] m, input int n);
		@(posedge clk);
		#1;
		for (int b = 0; b < n; b++) begin
			dataIn = d[b*18+:18];
			lane_write_masks_n = m[b*2+:2];
			@(posedge clk);
			#1;
		end
		dataIn = ~dataIn;
		lane_write_masks_n = 2'h3;
	endtask
endmodule

// ===== tb/bsr_cmd_port_test.sv
// Self-checking bench for the SRAM command port against a lane-accurate memory image.
`timescale 1ns/1ps
module bsr_cmd_port_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic readSel_n, writeSel_n, dataOutOe, read_data_valid, kPhase;
	logic [18:0] addr;
	logic [17:0] dataIn, dataOut;
	logic [1:0] lane_write_masks_n;
	logic [17:0] mem [0:31];
	int seed = 34;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	bsr_cmd_port u_dut (.clk(clk), .rst_n(rst_n), .readSel_n(readSel_n), .writeSel_n(writeSel_n), .addr(addr),
		.dataIn(dataIn), .lane_write_masks_n(lane_write_masks_n), .dataOut(dataOut), .dataOutOe(dataOutOe),
		.read_data_valid(read_data_valid), .kPhase(kPhase));
	bsr_ctl_model u_ctl (.clk(clk), .kPhase(kPhase), .readSel_n(readSel_n), .writeSel_n(writeSel_n),
		.addr(addr), .dataIn(dataIn), .lane_write_masks_n(lane_write_masks_n));
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic on(input int k, input int lo, input int hi, input int m);
		return (k >= lo && k <= hi) || (m == 2 && k >= lo + 4 && k <= hi + 4);
	endfunction
	function automatic void note(input logic [18:0] a, input logic [71:0] d, input logic [7:0] m);
		for (int i = 0; i < 72; i++) begin
			if (!m[i/18*2+i%18/9]) begin
				mem[{a[2:0], 2'(i / 18)}][i%18] = d[i];
			end
		end
	endfunction
	task automatic wr(input logic [18:0] a, input logic [71:0] d, input logic [7:0] m);
		u_ctl.cmd(1'b0, 1'b1, a, 1'b0);
		u_ctl.data({72'h0, d}, {8'h0, m}, 4);
		note(a, d, m);
	endtask
	// Two writes four clocks apart, their eight beats sent back to back.
	task automatic ww(input logic [18:0] a1, input logic [18:0] a2, input logic [7:0] m);
		logic [71:0] d1, d2;
		d1 = 72'({$random(seed), $random(seed), $random(seed)});
		d2 = 72'({$random(seed), $random(seed), $random(seed)});
		u_ctl.cmd(1'b0, 1'b1, a1, 1'b0);
		fork
			begin
				repeat (2) @(posedge clk);
				u_ctl.cmd(1'b0, 1'b1, a2, 1'b0);
			end
			u_ctl.data({d2, d1}, {m, m}, 8);
		join
		note(a1, d1, m);
		note(a2, d2, m);
	endtask
	// Mode 1 adds an ignored read two clocks on, mode 2 a taken read four clocks on,
	// mode 3 raises the write select beside the read after an idle cycle.
	task automatic rd(input logic [18:0] a, input int m);
		u_ctl.cmd(1'b1, m == 3, a, 1'b0);
		if (m == 3) begin
			fork
				u_ctl.data(144'h0, 16'h0, 4);
			join_none
		end
		if (m == 2) begin
			repeat (2) @(posedge clk);
		end
		if (m == 1 || m == 2) begin
			u_ctl.cmd(1'b1, 1'b0, m == 2 ? a : a ^ 19'h1, 1'b0);
		end
		for (int k = (m % 3) * 2 + 1; k < 15; k++) begin
			@(posedge clk);
			#1;
			chk(18'(read_data_valid), 18'(on(k, 6, 8, m)));
			chk(18'(dataOutOe), 18'(on(k, 7, 10, m)));
			chk(dataOut, on(k, 7, 10, m) ? mem[{a[2:0], 2'((k - 7) % 4)}] : 18'h0);
		end
	endtask
	initial begin
		logic [18:0] a;
		repeat (4) @(posedge clk);
		#1;
		chk(18'(dataOutOe), 18'h0);
		chk(18'(kPhase), 18'h0);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(19'(i), 72'({$random(seed), $random(seed), $random(seed)}), 8'h0);
		end
		for (int n = 0; n < 40; n++) begin
			a = 19'($random(seed) & 7);
			wr(a, 72'({$random(seed), $random(seed), $random(seed)}), 8'($random(seed)));
			rd(a, n % 3);
		end
		ww(19'h2, 19'h6, 8'($random(seed)));
		rd(19'h2, 0);
		rd(19'h6, 0);
		rd(19'h3, 3);
		repeat (8) @(posedge clk);
		rd(19'h3, 0);
		u_ctl.cmd(1'b1, 1'b1, 19'h5, 1'b1);
		u_ctl.data(144'h0, 16'h0, 4);
		rd(19'h5, 0);
		test_done();
	end
endmodule
bind bsr_cmd_port bsr_chk u_chk (.clk(clk), .rst_n(rst_n), .readSel_n(readSel_n), .dataOut(dataOut),
	.dataOutOe(dataOutOe), .read_data_valid(read_data_valid), .kPhase(kPhase));
